/* hdl/psc_pkg.sv */
// package of constants for the performance-state request and activity counters
// assumes one core clock and a model-register access port driven by the core
package psc_pkg;
  localparam logic [31:0] PSC_IDX_REF_CNT = 32'h000000E7;
  localparam logic [31:0] PSC_IDX_ACT_CNT = 32'h000000E8;
  localparam logic [31:0] PSC_IDX_STATUS = 32'h00000198;
  localparam logic [31:0] PSC_IDX_CONTROL = 32'h00000199;
  localparam logic [31:0] PSC_IDX_MISC_EN = 32'h000001A0;
  localparam int PSC_MISC_EN_BIT = 16;
  localparam int PSC_ID1_ECX_BIT = 7;
  localparam int PSC_ID6_ECX_BIT = 0;
  localparam int PSC_CODE_W = 16;
  localparam int PSC_CNT_W = 64;
  localparam int PSC_NUM_CODES = 4;
  localparam logic [15:0] PSC_DEFAULT_CODE = 16'h0000;
  localparam logic [63:0] PSC_CNT_RESET = 64'h0000000000000000;
  localparam logic [7:0] PSC_STEP_CYCLES = 8'h10;
  localparam logic [7:0] PSC_RATE_MAX = 8'hFF;
  typedef enum logic [1:0] {PSC_IDLE, PSC_MOVING} psc_state_t;
endpackage

/* hdl/psc_feedback_counter.sv */
// one 64-bit feedback counter with write load and shared clear
// assumes the owner decides increment amount and clear for the pair
`timescale 1ns/100ps
module psc_feedback_counter
  import psc_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // counting
  input wire logic [7:0] incr,
  input wire logic clear_pair,
  // software load
  input wire logic load,
  input wire logic [63:0] load_value,
  // state
  output logic [63:0] count,
  output logic wraps
);
  logic [64:0] sum;

  // carry out marks a wrap past the top value
  assign sum = {1'b0, count} + {57'h0, incr};
  assign wraps = sum[64] & ~load;

  // load beats both clear of the pair and counting; clear of the pair beats counting
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      count <= PSC_CNT_RESET;
    else if (clk_en)
    begin
      if (load)
        count <= load_value;
      else if (clear_pair)
        count <= PSC_CNT_RESET;
      else
        count <= sum[63:0];
    end
  end
endmodule // psc_feedback_counter

/* hdl/psc_perf_state.sv */
// performance-state request logic and activity feedback counters
// assumes model-register read and write strobes are single-cycle, synchronous
`timescale 1ns/100ps
module psc_perf_state
  import psc_pkg::*;
#(
  parameter logic [15:0] VALID_CODES [PSC_NUM_CODES] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003}
)
(
  // clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // model-register access port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_index,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_error,
  // identification capability bits
  output logic id1_ecx_transition,
  output logic id6_ecx_feedback,
  // core activity
  input wire logic core_in_c0,
  input wire logic ref_tick,
  input wire logic [7:0] perf_rate,
  // operating point toward regulation
  output logic [15:0] op_point,
  output logic transition_busy
);
  logic [63:0] misc_reg;
  logic [15:0] target_reg;
  logic [15:0] pending_reg;
  logic pending_valid_reg;
  logic [15:0] status_reg;
  logic [15:0] dest_reg;
  logic [7:0] step_reg;
  psc_state_t state_reg;
  logic [63:0] ref_count;
  logic [63:0] act_count;
  logic ref_wrap;
  logic act_wrap;
  logic wr_ctl;
  logic code_ok;
  logic [7:0] ref_inc;
  logic [7:0] act_inc;
  logic [63:0] rdata_next;
  logic err_next;
  logic [PSC_NUM_CODES-1:0] code_hit;
  logic [7:0] move_age_reg;

  // constant capability flags
  assign id1_ecx_transition = 1'b1;
  assign id6_ecx_feedback = 1'b1;

  // one comparator per table entry; any hit makes the written code valid
  for (genvar g = 0; g < PSC_NUM_CODES; g++)
  begin : g_code
    assign code_hit[g] = (VALID_CODES[g] == reg_wdata[15:0]);
  end
  assign code_ok = |code_hit;

  // invalid codes are dropped so the regulator never sees them
  assign wr_ctl = reg_write && (reg_index == PSC_IDX_CONTROL) && code_ok;

  // enable register, cleared at every reset
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      misc_reg <= 64'h0000000000000000;
    else if (clk_en && reg_write && reg_index == PSC_IDX_MISC_EN)
      misc_reg <= reg_wdata;
  end

  // last written target, what a control read returns
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      target_reg <= PSC_DEFAULT_CODE;
    else if (clk_en && wr_ctl)
      target_reg <= reg_wdata[15:0];
  end

  // transition sequencer; a request mid-move is queued in one slot, where a later request replaces it
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg <= PSC_IDLE;
      status_reg <= PSC_DEFAULT_CODE;
      dest_reg <= PSC_DEFAULT_CODE;
      pending_reg <= PSC_DEFAULT_CODE;
      pending_valid_reg <= 1'b0;
      step_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      case (state_reg)
        PSC_IDLE:
        begin
          if (pending_valid_reg && misc_reg[PSC_MISC_EN_BIT])
          begin
            dest_reg <= pending_reg;
            pending_valid_reg <= wr_ctl;
            pending_reg <= wr_ctl ? reg_wdata[15:0] : pending_reg;
            step_reg <= PSC_STEP_CYCLES;
            state_reg <= PSC_MOVING;
          end
          else if (wr_ctl && misc_reg[PSC_MISC_EN_BIT])
          begin
            dest_reg <= reg_wdata[15:0];
            step_reg <= PSC_STEP_CYCLES;
            state_reg <= PSC_MOVING;
          end
          else if (wr_ctl)
          begin
            pending_reg <= reg_wdata[15:0];
            pending_valid_reg <= 1'b1;
          end
        end
        PSC_MOVING:
        begin
          if (wr_ctl)
          begin
            pending_reg <= reg_wdata[15:0];
            pending_valid_reg <= 1'b1;
          end
          if (step_reg == 8'h01)
          begin
            status_reg <= dest_reg;
            state_reg <= PSC_IDLE;
          end
          step_reg <= step_reg - 8'h01;
        end
        default:
          state_reg <= PSC_IDLE;
      endcase
    end
  end

  assign op_point = status_reg;
  assign transition_busy = (state_reg == PSC_MOVING);

  // counting only on a reference tick in c0; actual adds perf_rate per tick
  assign ref_inc = (core_in_c0 && ref_tick) ? 8'h01 : 8'h00;
  assign act_inc = (core_in_c0 && ref_tick) ? perf_rate : 8'h00;

  psc_feedback_counter u_ref_cnt (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .incr(ref_inc),
    .clear_pair(ref_wrap | act_wrap),
    .load(reg_write && reg_index == PSC_IDX_REF_CNT),
    .load_value(reg_wdata),
    .count(ref_count),
    .wraps(ref_wrap)
  );

  psc_feedback_counter u_act_cnt (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .incr(act_inc),
    .clear_pair(ref_wrap | act_wrap),
    .load(reg_write && reg_index == PSC_IDX_ACT_CNT),
    .load_value(reg_wdata),
    .count(act_count),
    .wraps(act_wrap)
  );

  // read decode; unknown index answers zero with error
  always_comb
  begin
    rdata_next = 64'h0000000000000000;
    err_next = 1'b0;
    if (reg_index == PSC_IDX_REF_CNT)
      rdata_next = ref_count;
    else if (reg_index == PSC_IDX_ACT_CNT)
      rdata_next = act_count;
    else if (reg_index == PSC_IDX_CONTROL)
      rdata_next = {48'h000000000000, target_reg};
    else if (reg_index == PSC_IDX_STATUS)
      rdata_next = {48'h000000000000, status_reg};
    else if (reg_index == PSC_IDX_MISC_EN)
      rdata_next = misc_reg;
    else
      err_next = 1'b1;
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 64'h0000000000000000;
      reg_error <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata <= reg_read ? rdata_next : reg_rdata;
      reg_error <= reg_read && err_next;
    end
  end

  a_enable_reset: assert property (@(posedge clock) !reset_n |=> misc_reg[PSC_MISC_EN_BIT] == 1'b0)
    else $error("enable bit not cleared by reset");
  a_no_move_disabled: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && state_reg == PSC_IDLE && !misc_reg[PSC_MISC_EN_BIT]) |=> state_reg == PSC_IDLE)
    else $error("transition began while disabled");
  a_ctl_readback: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && wr_ctl) |=> target_reg == $past(reg_wdata[15:0]))
    else $error("control readback not last target");
  a_queue_mid_move: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && wr_ctl && state_reg == PSC_MOVING) |=> pending_valid_reg)
    else $error("request during transition lost");
  a_status_lands: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && state_reg == PSC_MOVING && step_reg == 8'h01) |=> status_reg == $past(dest_reg))
    else $error("status did not reach destination");
  a_hold_outside_c0: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && !core_in_c0 && !reg_write) |=> $stable(ref_count) && $stable(act_count))
    else $error("counter moved outside c0");
  a_pair_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && act_wrap && !reg_write) |=> ref_count == 64'h0 && act_count == 64'h0)
    else $error("wrap did not clear both");
  a_ref_step: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && core_in_c0 && ref_tick && !reg_write && !ref_wrap && !act_wrap)
    |=> ref_count == $past(ref_count) + 64'h1)
    else $error("reference counter missed a tick");
  a_load_alone: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_write && reg_index == PSC_IDX_REF_CNT && !ref_wrap && !act_wrap && act_inc == 8'h00)
    |=> ref_count == $past(reg_wdata) && $stable(act_count))
    else $error("counter load disturbed pair");
  a_act_load_alone: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_write && reg_index == PSC_IDX_ACT_CNT && !ref_wrap && !act_wrap && ref_inc == 8'h00)
    |=> act_count == $past(reg_wdata) && $stable(ref_count))
    else $error("actual load disturbed pair");

  // age of the current move, kept apart from the step counter it checks
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      move_age_reg <= 8'h00;
    else if (clk_en)
      move_age_reg <= transition_busy ? move_age_reg + 8'h01 : 8'h00;
  end

  // a move lasts the fixed step count, never longer
  a_move_bounded: assert property (@(posedge clock) disable iff (!reset_n)
    move_age_reg <= PSC_STEP_CYCLES)
    else $error("transition ran too long");
  a_move_length: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && state_reg == PSC_MOVING && step_reg == 8'h01) |-> move_age_reg == PSC_STEP_CYCLES - 8'h01)
    else $error("transition landed early");
  a_direct_start: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && state_reg == PSC_IDLE && !pending_valid_reg && wr_ctl && misc_reg[PSC_MISC_EN_BIT])
    |=> transition_busy && dest_reg == $past(reg_wdata[15:0]))
    else $error("enabled write did not start a move");
  a_queued_start: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && state_reg == PSC_IDLE && pending_valid_reg && misc_reg[PSC_MISC_EN_BIT])
    |=> state_reg == PSC_MOVING && dest_reg == $past(pending_reg))
    else $error("queued target not applied");

  // status moves only when a move lands; target only on an accepted write
  a_status_only_lands: assert property (@(posedge clock) disable iff (!reset_n)
    !(clk_en && state_reg == PSC_MOVING && step_reg == 8'h01) |=> $stable(status_reg))
    else $error("status changed outside a landing");
  a_target_holds: assert property (@(posedge clock) disable iff (!reset_n)
    !(clk_en && wr_ctl) |=> $stable(target_reg))
    else $error("target changed without a write");
  a_bad_code_dropped: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_write && reg_index == PSC_IDX_CONTROL && !code_ok) |=> $stable(target_reg))
    else $error("invalid code accepted");

  // control, status and both counter reads answer with their value at the strobe
  a_ctl_reads_target: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_read && reg_index == PSC_IDX_CONTROL)
    |=> reg_rdata == {48'h000000000000, $past(target_reg)})
    else $error("control read not the target");
  a_status_readback: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_read && reg_index == PSC_IDX_STATUS)
    |=> reg_rdata == {48'h000000000000, $past(status_reg)})
    else $error("status read not the point in force");
  a_ref_readback: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_read && reg_index == PSC_IDX_REF_CNT) |=> reg_rdata == $past(ref_count))
    else $error("reference read mismatch");
  a_act_readback: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && reg_read && reg_index == PSC_IDX_ACT_CNT) |=> reg_rdata == $past(act_count))
    else $error("actual read mismatch");

  // counting steps, holds and the shared clear
  a_act_step: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && core_in_c0 && ref_tick && !reg_write && !ref_wrap && !act_wrap)
    |=> act_count == $past(act_count) + {56'h00000000000000, $past(perf_rate)})
    else $error("actual counter missed its rate");
  a_hold_without_tick: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && !ref_tick && !reg_write) |=> $stable(ref_count) && $stable(act_count))
    else $error("counter moved without a tick");
  a_ref_wrap_clears: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && ref_wrap && !reg_write) |=> ref_count == PSC_CNT_RESET && act_count == PSC_CNT_RESET)
    else $error("reference wrap did not clear both");

  // every reset restores the documented start values
  a_reset_defaults: assert property (@(posedge clock)
    !reset_n |=> ref_count == PSC_CNT_RESET && act_count == PSC_CNT_RESET && status_reg == PSC_DEFAULT_CODE
      && target_reg == PSC_DEFAULT_CODE && !transition_busy)
    else $error("reset left a non-default value");
endmodule // psc_perf_state

/* sim/tb.sv */
// self-checking bench for the performance-state request and activity counters
// assumes psc_pkg is compiled first and the register port takes one access per strobe
`timescale 1ns/100ps
module tb;
  import psc_pkg::*;
  logic clock, reset_n, clk_en, reg_write, reg_read, core_in_c0, ref_tick;
  logic [31:0] reg_index;
  logic [63:0] reg_wdata, reg_rdata;
  logic [7:0] perf_rate;
  logic reg_error, id1_ecx_transition, id6_ecx_feedback, transition_busy;
  logic [15:0] op_point;
  int mismatches, comparisons;
  logic [63:0] saved_ref, saved_act;

  psc_perf_state dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .reg_write(reg_write),
    .reg_read(reg_read), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_error(reg_error), .id1_ecx_transition(id1_ecx_transition), .id6_ecx_feedback(id6_ecx_feedback),
    .core_in_c0(core_in_c0), .ref_tick(ref_tick), .perf_rate(perf_rate), .op_point(op_point),
    .transition_busy(transition_busy));

  // 50 MHz core clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write strobe, then a released cycle so strobes never merge
  task automatic wr(input logic [31:0] idx, input logic [63:0] data);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_index <= idx;
    reg_wdata <= data;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data and error settle one edge after the strobe is taken
  task automatic rd(input logic [31:0] idx, input logic [63:0] exp, input logic bad);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_index <= idx;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk({63'h0, reg_error}, {63'h0, bad});
    if (!bad)
      chk(reg_rdata, exp);
  endtask

  // activity inputs hold for exactly n sampling edges
  task automatic run(input logic c0, input logic tick, input logic [7:0] rate, input int n, input logic en);
    @(posedge clock);
    core_in_c0 <= c0;
    ref_tick <= tick;
    perf_rate <= rate;
    clk_en <= en;
    repeat (n) @(posedge clock);
    core_in_c0 <= 1'b0;
    ref_tick <= 1'b0;
    clk_en <= 1'b1;
  endtask

  // transitions take a bounded number of cycles; a miss shows as a mismatch
  task automatic wait_op(input logic [15:0] v);
    int k;
    k = 0;
    while (op_point !== v && k < 40)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    chk({48'h0, op_point}, {48'h0, v});
  endtask

  // watchdog, far beyond the fewer than two hundred cycles the sequence needs
  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    mismatches = 0;
    comparisons = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_index = 32'h00000000;
    reg_wdata = 64'h0000000000000000;
    core_in_c0 = 1'b0;
    ref_tick = 1'b0;
    perf_rate = 8'h00;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk({63'h0, id1_ecx_transition}, 64'h1);
    chk({63'h0, id6_ecx_feedback}, 64'h1);
    chk({48'h0, op_point}, {48'h0, PSC_DEFAULT_CODE});
    rd(PSC_IDX_REF_CNT, 64'h0, 1'b0);
    rd(PSC_IDX_ACT_CNT, 64'h0, 1'b0);
    rd(PSC_IDX_MISC_EN, 64'h0, 1'b0);
    rd(32'h00000010, 64'h0, 1'b1);
    // carry across bit 32, idle cycles, frozen clock enable
    wr(PSC_IDX_REF_CNT, 64'h00000001FFFFFFFF);
    rd(PSC_IDX_ACT_CNT, 64'h0, 1'b0);
    run(1'b1, 1'b1, 8'h03, 5, 1'b1);
    run(1'b0, 1'b1, 8'h03, 4, 1'b1);
    run(1'b1, 1'b1, 8'h03, 3, 1'b0);
    rd(PSC_IDX_REF_CNT, 64'h0000000200000004, 1'b0);
    rd(PSC_IDX_ACT_CNT, 64'h000000000000000F, 1'b0);
    // actual counter wraps on one tick; both clear, then keep counting
    wr(PSC_IDX_ACT_CNT, 64'hFFFFFFFFFFFFFFFE);
    wr(PSC_IDX_REF_CNT, 64'h0000000000000005);
    rd(PSC_IDX_ACT_CNT, 64'hFFFFFFFFFFFFFFFE, 1'b0);
    saved_act = reg_rdata;
    run(1'b1, 1'b1, 8'h02, 1, 1'b1);
    repeat (3) @(posedge clock);
    rd(PSC_IDX_REF_CNT, 64'h0, 1'b0);
    rd(PSC_IDX_ACT_CNT, 64'h0, 1'b0);
    chk({63'h0, (reg_rdata < saved_act)}, 64'h1);
    run(1'b1, 1'b1, 8'h02, 2, 1'b1);
    rd(PSC_IDX_REF_CNT, 64'h2, 1'b0);
    rd(PSC_IDX_ACT_CNT, 64'h4, 1'b0);
    // window start: pair zeroed back to back, then a window at rate three
    wr(PSC_IDX_REF_CNT, 64'h0);
    wr(PSC_IDX_ACT_CNT, 64'h0);
    run(1'b1, 1'b1, 8'h03, 6, 1'b1);
    rd(PSC_IDX_REF_CNT, 64'h6, 1'b0);
    saved_ref = reg_rdata;
    rd(PSC_IDX_ACT_CNT, 64'h12, 1'b0);
    chk(reg_rdata, saved_ref * 64'h3);
    // reference counter wraps; the actual one clears with it
    wr(PSC_IDX_REF_CNT, 64'hFFFFFFFFFFFFFFFF);
    run(1'b1, 1'b1, 8'h01, 1, 1'b1);
    rd(PSC_IDX_REF_CNT, 64'h0, 1'b0);
    rd(PSC_IDX_ACT_CNT, 64'h0, 1'b0);
    // target written while disabled waits for the enable bit
    wr(PSC_IDX_CONTROL, 64'h2);
    rd(PSC_IDX_CONTROL, 64'h2, 1'b0);
    repeat (20) @(posedge clock);
    rd(PSC_IDX_STATUS, 64'h0, 1'b0);
    wr(PSC_IDX_MISC_EN, 64'h0000000000010000);
    repeat (3) @(posedge clock);
    #1;
    chk({63'h0, transition_busy}, 64'h1);
    wait_op(16'h0002);
    chk({63'h0, transition_busy}, 64'h0);
    rd(PSC_IDX_STATUS, 64'h2, 1'b0);
    rd(PSC_IDX_MISC_EN, 64'h0000000000010000, 1'b0);
    // second target during a transition is kept and applied after it
    wr(PSC_IDX_CONTROL, 64'h1);
    repeat (2) @(posedge clock);
    wr(PSC_IDX_CONTROL, 64'h3);
    rd(PSC_IDX_CONTROL, 64'h3, 1'b0);
    wait_op(16'h0001);
    wait_op(16'h0003);
    // code outside the table leaves the target alone
    wr(PSC_IDX_CONTROL, 64'h7);
    rd(PSC_IDX_CONTROL, 64'h3, 1'b0);
    rd(PSC_IDX_STATUS, 64'h3, 1'b0);
    // reset in mid-run clears the enable and restores the default point
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    rd(PSC_IDX_MISC_EN, 64'h0, 1'b0);
    rd(PSC_IDX_CONTROL, {48'h0, PSC_DEFAULT_CODE}, 1'b0);
    chk({48'h0, op_point}, {48'h0, PSC_DEFAULT_CODE});
    chk({63'h0, transition_busy}, 64'h0);
    give_verdict();
  end
endmodule // tb
